// *** design/drm_top.sv ***
// display ram address mapper: apb registers, write pointer, scan-out
//
// Functional notes
// - memory holds 128x128 pixels, 4 bits each
// - command code a0h loads remap option bits
// - normally low nibble drives even column output
// - horizontal mode advances column first, then row
// - vertical mode advances row first, then column
// - column reversal puts column 3fh first
// - nibble reversal puts high nibble on even
// - row reversal scans memory rows descending
// - start line offsets which output shows row 0
// - writes stay inside programmed column/row window
`timescale 1ns/100ps
module drm_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output drm_pkg::drm_pix_t pix
);
  import drm_pkg::*;

  // ==========================================================
  // registers
  drm_remap_t       remap_q;
  logic [ROW_W-1:0] start_q;
  logic [COL_W-1:0] col_start_q;
  logic [COL_W-1:0] col_end_q;
  logic [ROW_W-1:0] row_start_q;
  logic [ROW_W-1:0] row_end_q;
  logic [COL_W-1:0] ptr_col_q;
  logic [COL_W-1:0] ptr_col_d;
  logic [ROW_W-1:0] ptr_row_q;
  logic [ROW_W-1:0] ptr_row_d;
  logic [31:0]      rd_val;

  // ==========================================================
  // apb decode
  wire              apb_acc;
  wire              apb_fire;
  wire              wr_fire;
  wire              sel_cmd;
  wire              sel_data;
  wire              sel_start;
  wire              sel_colwin;
  wire              sel_rowwin;
  wire              sel_status;
  wire              hit;
  wire              cmd_wr;
  wire              remap_wr;
  wire              data_wr;
  wire              start_wr;
  wire              colwin_wr;
  wire              rowwin_wr;
  wire [COL_W-1:0]  new_col_start;
  wire [COL_W-1:0]  new_col_end;
  wire [ROW_W-1:0]  new_row_start;
  wire [ROW_W-1:0]  new_row_end;
  wire              col_last;
  wire              row_last;
  wire [ADDR_W-1:0] scan_addr;
  wire [7:0]        scan_data;
  wire              unused_ok;

  // one wait state: the access phase sees pready on its second cycle
  assign apb_acc    = psel & penable;
  assign apb_fire   = apb_acc & pready;
  assign wr_fire    = apb_fire & pwrite;

  assign sel_cmd    = paddr == OFF_CMD;
  assign sel_data   = paddr == OFF_DATA;
  assign sel_start  = paddr == OFF_START;
  assign sel_colwin = paddr == OFF_COLWIN;
  assign sel_rowwin = paddr == OFF_ROWWIN;
  assign sel_status = paddr == OFF_STATUS;
  assign hit        = sel_cmd | sel_data | sel_start | sel_colwin | sel_rowwin | sel_status;

  // command path carries code and option; data path carries pixels
  assign cmd_wr     = wr_fire & sel_cmd;
  assign remap_wr   = cmd_wr & (pwdata[CMD_CODE_LSB +: 8] == CMD_REMAP);
  assign data_wr    = wr_fire & sel_data;
  assign start_wr   = wr_fire & sel_start;
  assign colwin_wr  = wr_fire & sel_colwin;
  assign rowwin_wr  = wr_fire & sel_rowwin;

  assign new_col_start = pwdata[COL_W-1:0];
  assign new_col_end   = pwdata[WIN_END_LSB +: COL_W];
  assign new_row_start = pwdata[ROW_W-1:0];
  assign new_row_end   = pwdata[WIN_END_LSB +: ROW_W];

  // ==========================================================
  // apb answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~hit;
      prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // read mux; the data path is write only and reads as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (sel_cmd) begin
      rd_val[CMD_CODE_LSB +: 8] = CMD_REMAP;
      rd_val[7:0]               = remap_q;
    end else if (sel_start) begin
      rd_val[ROW_W-1:0] = start_q;
    end else if (sel_colwin) begin
      rd_val[COL_W-1:0]                = col_start_q;
      rd_val[WIN_END_LSB +: COL_W]     = col_end_q;
    end else if (sel_rowwin) begin
      rd_val[ROW_W-1:0]                = row_start_q;
      rd_val[WIN_END_LSB +: ROW_W]     = row_end_q;
    end else if (sel_status) begin
      rd_val[COL_W-1:0]                = ptr_col_q;
      rd_val[STAT_ROW_LSB +: ROW_W]    = ptr_row_q;
      rd_val[STAT_COM_LSB +: ROW_W]    = pix.com;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      remap_q <= REMAP_RST;
      start_q <= START_RST;
    end else begin
      if (remap_wr) begin
        remap_q <= pwdata[7:0];
      end
      if (start_wr) begin
        start_q <= pwdata[ROW_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      col_start_q <= COL_START_RST;
      col_end_q   <= COL_END_RST;
      row_start_q <= ROW_START_RST;
      row_end_q   <= ROW_END_RST;
    end else begin
      if (colwin_wr) begin
        col_start_q <= new_col_start;
        col_end_q   <= new_col_end;
      end
      if (rowwin_wr) begin
        row_start_q <= new_row_start;
        row_end_q   <= new_row_end;
      end
    end
  end

  // ==========================================================
  // write pointer
  assign col_last = ptr_col_q == col_end_q;
  assign row_last = ptr_row_q == row_end_q;

  always_comb begin
    ptr_col_d = ptr_col_q;
    ptr_row_d = ptr_row_q;
    if (colwin_wr) begin
      // a new window restarts the pointer at its corner
      ptr_col_d = new_col_start;
      ptr_row_d = row_start_q;
    end else if (rowwin_wr) begin
      ptr_col_d = col_start_q;
      ptr_row_d = new_row_start;
    end else if (data_wr && !remap_q.vert_inc) begin
      if (col_last) begin
        ptr_col_d = col_start_q;
        ptr_row_d = row_last ? row_start_q : ptr_row_q + 7'h01;
      end else begin
        ptr_col_d = ptr_col_q + 6'h01;
      end
    end else if (data_wr) begin
      if (row_last) begin
        ptr_row_d = row_start_q;
        ptr_col_d = col_last ? col_start_q : ptr_col_q + 6'h01;
      end else begin
        ptr_row_d = ptr_row_q + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptr_col_q <= COL_START_RST;
      ptr_row_q <= ROW_START_RST;
    end else begin
      ptr_col_q <= ptr_col_d;
      ptr_row_q <= ptr_row_d;
    end
  end

  // ==========================================================
  // memory and scan-out; only the data path writes the memory
  drm_ram u_ram (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .wr_en   (data_wr),
    .wr_addr ({ptr_row_q, ptr_col_q}),
    .wr_data (pwdata[7:0]),
    .rd_addr (scan_addr),
    .rd_data (scan_data)
  );

  drm_scan u_scan (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .remap      (remap_q),
    .start_line (start_q),
    .rd_addr    (scan_addr),
    .rd_data    (scan_data),
    .pix        (pix)
  );

  // reserved option bits are stored but steer nothing
  assign unused_ok = &{1'b0, remap_q.rsv_hi, remap_q.rsv3};

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_hstep;
    data_wr && !remap_q.vert_inc && !col_last;
  endsequence

  sequence s_vstep;
    data_wr && remap_q.vert_inc && !row_last;
  endsequence

  sequence s_win_end;
    data_wr && col_last && row_last;
  endsequence

  a_horiz_step: assert property (
    s_hstep |=> ptr_col_q == 6'($past(ptr_col_q) + 6'h01) && $stable(ptr_row_q))
    else $error("horizontal step did not advance column");

  a_horiz_line: assert property (
    (data_wr && !remap_q.vert_inc && col_last && !row_last && !colwin_wr)
      |=> ptr_col_q == $past(col_start_q) && ptr_row_q == 7'($past(ptr_row_q) + 7'h01))
    else $error("end of line did not move to next row");

  a_vert_step: assert property (
    s_vstep |=> ptr_row_q == 7'($past(ptr_row_q) + 7'h01) && $stable(ptr_col_q))
    else $error("vertical step did not advance row");

  a_ptr_wrap: assert property (
    s_win_end |=> ptr_col_q == $past(col_start_q) && ptr_row_q == $past(row_start_q))
    else $error("pointer did not wrap to window start");

  a_ptr_window: assert property (
    (col_start_q <= col_end_q && row_start_q <= row_end_q)
      |-> ptr_col_q >= col_start_q && ptr_col_q <= col_end_q
       && ptr_row_q >= row_start_q && ptr_row_q <= row_end_q)
    else $error("write pointer left the window");

  a_remap_load: assert property (
    remap_wr |=> remap_q == $past(pwdata[7:0]))
    else $error("remap command not applied");

  a_remap_keep: assert property (
    (cmd_wr && !remap_wr) |=> $stable(remap_q))
    else $error("foreign command changed remap");

  a_apb_answer: assert property (
    (apb_acc && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle long");

  a_vert_line: assert property (
    (data_wr && remap_q.vert_inc && row_last && !col_last)
      |=> ptr_row_q == $past(row_start_q) && ptr_col_q == 6'($past(ptr_col_q) + 6'h01))
    else $error("end of column did not move to next column");

  a_col_restart: assert property (
    colwin_wr |=> ptr_col_q == $past(new_col_start) && ptr_row_q == $past(row_start_q))
    else $error("new column window did not restart pointer");

  a_row_restart: assert property (
    rowwin_wr |=> ptr_col_q == $past(col_start_q) && ptr_row_q == $past(new_row_start))
    else $error("new row window did not restart pointer");

  a_bad_addr: assert property (
    (apb_acc && !pready) |=> pslverr == !$past(hit))
    else $error("slave error does not match address decode");

endmodule : drm_top

// *** design/drm_pkg.sv ***
// constants and carriers shared by the display ram address mapper
package drm_pkg;

  // ==========================================================
  // pixel memory geometry
  localparam int unsigned COL_W   = 6;
  localparam int unsigned ROW_W   = 7;
  localparam int unsigned ADDR_W  = COL_W + ROW_W;
  localparam int unsigned DEPTH   = 8192;

  // ==========================================================
  // register byte offsets on the apb
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_START  = 8'h08;
  localparam logic [7:0] OFF_COLWIN = 8'h0c;
  localparam logic [7:0] OFF_ROWWIN = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ==========================================================
  // field positions
  localparam int unsigned CMD_CODE_LSB = 8;
  localparam int unsigned WIN_END_LSB  = 8;
  localparam int unsigned STAT_ROW_LSB = 8;
  localparam int unsigned STAT_COM_LSB = 16;

  // ==========================================================
  // command codes and reset values
  localparam logic [7:0]       CMD_REMAP     = 8'ha0;
  localparam logic [7:0]       REMAP_RST     = 8'h00;
  localparam logic [ROW_W-1:0] START_RST     = 7'h00;
  localparam logic [COL_W-1:0] COL_START_RST = 6'h00;
  localparam logic [COL_W-1:0] COL_END_RST   = 6'h3f;
  localparam logic [ROW_W-1:0] ROW_START_RST = 7'h00;
  localparam logic [ROW_W-1:0] ROW_END_RST   = 7'h7f;

  // ==========================================================
  // remap option byte, bit positions as carried by the command
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       row_rev;
    logic       rsv3;
    logic       vert_inc;
    logic       nib_rev;
    logic       col_rev;
  } drm_remap_t;

  // one column-drive pair as scanned out
  typedef struct packed {
    logic             valid;
    logic [ROW_W-1:0] com;
    logic [COL_W-1:0] pair;
    logic [3:0]       even;
    logic [3:0]       odd;
  } drm_pix_t;

endpackage : drm_pkg

// *** design/drm_ram.sv ***
// display pixel ram: one write port, one registered read port
`timescale 1ns/100ps
module drm_ram (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       wr_en,
  input  wire logic [drm_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]                 wr_data,
  input  wire logic [drm_pkg::ADDR_W-1:0] rd_addr,
  output logic      [7:0]                 rd_data
);
  import drm_pkg::*;

  // 128 rows x 64 bytes, two 4-bit pixels per byte
  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : drm_ram

// *** design/drm_scan.sv ***
// scan engine: maps memory onto row and column drive order
`timescale 1ns/100ps
module drm_scan (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  drm_pkg::drm_remap_t             remap,
  input  wire logic [drm_pkg::ROW_W-1:0]  start_line,
  output logic      [drm_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic [7:0]                 rd_data,
  output drm_pkg::drm_pix_t               pix
);
  import drm_pkg::*;

  logic [ROW_W-1:0] com_q;
  logic [COL_W-1:0] pair_q;
  logic [ROW_W-1:0] com1_q;
  logic [COL_W-1:0] pair1_q;
  logic             nib1_q;
  logic             vld1_q;
  wire  [ROW_W-1:0] mem_row;
  wire  [COL_W-1:0] mem_col;

  // ==========================================================
  // output row c shows memory row start + c, or start + ~c reversed
  assign mem_row = start_line + (remap.row_rev ? ~com_q : com_q);
  assign mem_col = remap.col_rev ? ~pair_q : pair_q;
  assign rd_addr = {mem_row, mem_col};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      com_q   <= '0;
      pair_q  <= '0;
      com1_q  <= '0;
      pair1_q <= '0;
      nib1_q  <= 1'b0;
      vld1_q  <= 1'b0;
    end else begin
      pair_q  <= pair_q + 6'h01;
      com_q   <= (&pair_q) ? com_q + 7'h01 : com_q;
      com1_q  <= com_q;
      pair1_q <= pair_q;
      nib1_q  <= remap.nib_rev;
      vld1_q  <= 1'b1;
    end
  end

  // ==========================================================
  // low nibble to even output unless nibble reversal
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pix <= '0;
    end else begin
      pix.valid <= vld1_q;
      pix.com   <= com1_q;
      pix.pair  <= pair1_q;
      pix.even  <= nib1_q ? rd_data[7:4] : rd_data[3:0];
      pix.odd   <= nib1_q ? rd_data[3:0] : rd_data[7:4];
    end
  end

  // ==========================================================
  // checks
  a_nibble_map: assert property (
    @(posedge mclk) disable iff (sys_rst)
    pix.valid |-> (pix.even == ($past(nib1_q) ? $past(rd_data[7:4]) : $past(rd_data[3:0])))
              && (pix.odd == ($past(nib1_q) ? $past(rd_data[3:0]) : $past(rd_data[7:4]))))
    else $error("nibble order wrong on column pair");

  a_row_map: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (pix.valid && $past(vld1_q, 2)) |-> $past(rd_addr[ADDR_W-1:COL_W], 2) ==
      7'($past(start_line, 2) + ($past(remap.row_rev, 2) ? ~pix.com : pix.com)))
    else $error("row output shows wrong memory row");

  a_col_map: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (pix.valid && $past(vld1_q, 2)) |-> $past(rd_addr[COL_W-1:0], 2) ==
      ($past(remap.col_rev, 2) ? ~pix.pair : pix.pair))
    else $error("column pair shows wrong memory column");

endmodule : drm_scan

// *** sim/drm_host.sv ***
// host model: apb master that issues commands and pixel bytes to the mapper
`timescale 1ns/100ps
module drm_host (
  input  wire logic        mclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  // ==========================================================
  // idle state
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================
  // one transfer: setup, access, hold until pready
  // commands and pixel bytes go out on separate offsets
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // released address and data lines must not keep their last value
    paddr   <= ~addr;
    pwdata  <= ~data;
  endtask : xfer
endmodule : drm_host

// *** sim/drm_top_bench.sv ***
// self-checking bench for the display ram address mapper
`timescale 1ns/100ps
module drm_top_bench;
  import drm_pkg::*;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
    logic        err;
  } drm_note_t;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] PTR = 32'h0000_7f3f;
  logic        mclk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  drm_pix_t    pix;
  drm_note_t   notes[$];
  drm_note_t   note;
  drm_remap_t  rm;
  int          error_cnt;
  int          comparisons;
  int          seed;
  logic [7:0]  mem [DEPTH];
  logic [7:0]  opts [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h10, 8'h00};
  logic [6:0]  starts [7] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h78, 7'h05};

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  drm_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pix(pix));
  drm_host host_u (.mclk(mclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ==========================================================
  // compare and report
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk_bus(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_bus

  task automatic chk_pix(input logic [8:0] exp, input logic [8:0] seen);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] pix expected %h seen %h", exp, seen);
    end
  endtask : chk_pix

  // ==========================================================
  // bus operations, each noting its expected answer
  task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] ev, input logic [31:0] m, input logic e);
    notes.push_back('{ev, m, e});
    host_u.xfer(wr, a, d);
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic ptr(input logic [6:0] row, input logic [5:0] col);
    op(1'b0, OFF_STATUS, 32'h0, {17'h0, row, 2'h0, col}, PTR, 1'b0);
  endtask : ptr

  task automatic fill(input int n, input logic rec);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      if (rec)
        mem[i] = b;
      wr(OFF_DATA, {24'h0, b});
    end
  endtask : fill

  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0)
        chk_bus("unexpected pready", 32'h0, 32'h1);
      else begin
        note = notes.pop_front();
        chk_bus("prdata", note.val & note.mask, prdata & note.mask);
        chk_bus("pslverr", {31'h0, note.err}, {31'h0, pslverr});
      end
    end
  end

  // ==========================================================
  // watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] run expected done seen timeout");
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [6:0] r;
    logic [5:0] c;
    logic [7:0] b;
    logic [12:0] pos;
    seed = 32'h3c93;
    error_cnt = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge mclk);
    chk_bus("pix in reset", 32'h0, {10'h0, pix});
    sys_rst <= 1'b0;
    op(1'b0, OFF_CMD, 32'h0, 32'h0000_a000, ALL, 1'b0);
    op(1'b0, OFF_COLWIN, 32'h0, 32'h0000_3f00, ALL, 1'b0);
    op(1'b0, OFF_ROWWIN, 32'h0, 32'h0000_7f00, ALL, 1'b0);
    op(1'b0, OFF_START, 32'h0, 32'h0, ALL, 1'b0);
    op(1'b1, 8'h18, 32'h1, 32'h0, ALL, 1'b1);
    op(1'b0, 8'h18, 32'h0, 32'h0, ALL, 1'b1);
    fill(65, 1'b0);
    ptr(7'h01, 6'h01);
    wr(OFF_CMD, 32'h0000_a004);
    wr(OFF_CMD, 32'h0000_5500);
    op(1'b0, OFF_CMD, 32'h0, 32'h0000_a004, ALL, 1'b0);
    wr(OFF_COLWIN, 32'h0000_3f00);
    wr(OFF_ROWWIN, 32'h0000_7f00);
    fill(129, 1'b0);
    ptr(7'h01, 6'h01);
    wr(OFF_CMD, 32'h0000_a000);
    wr(OFF_COLWIN, 32'h0000_3e01);
    wr(OFF_ROWWIN, 32'h0000_7e01);
    fill(62, 1'b0);
    ptr(7'h02, 6'h01);
    fill(7750, 1'b0);
    ptr(7'h01, 6'h01);
    wr(OFF_COLWIN, 32'h0000_3f00);
    wr(OFF_ROWWIN, 32'h0000_7f00);
    fill(8192, 1'b1);
    ptr(7'h00, 6'h00);
    for (int m = 0; m < 7; m++) begin
      rm = drm_remap_t'(opts[m]);
      wr(OFF_CMD, {16'h0, CMD_REMAP, opts[m]});
      wr(OFF_START, {25'h0, starts[m]});
      repeat (4) @(posedge mclk);
      pos = {pix.com, pix.pair} + 13'h0001;
      repeat (2048) begin
        @(posedge mclk);
        chk_bus("scan position", {19'h0, pos}, {19'h0, pix.com, pix.pair});
        pos = pos + 13'h0001;
        r = starts[m] + (rm.row_rev ? ~pix.com : pix.com);
        c = rm.col_rev ? 6'h3f - pix.pair : pix.pair;
        b = mem[{r, c}];
        chk_pix(rm.nib_rev ? {1'b1, b} : {1'b1, b[3:0], b[7:4]}, {pix.valid, pix.even, pix.odd});
      end
    end
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule : drm_top_bench
